//--- inc/cam_acq_consts.svh
// Register map, field positions and reset values of the acquisition block
`ifndef CAM_ACQ_CONSTS_SVH
`define CAM_ACQ_CONSTS_SVH
`define ADDR_CTRL      8'h00
`define ADDR_EXPOSURE  8'h04
`define ADDR_MIN_PER   8'h08
`define ADDR_FORMAT    8'h0C
`define ADDR_GEOMETRY  8'h10
`define ADDR_SOFT_TRIG 8'h14
`define ADDR_STATUS    8'h18
`define ADDR_ROI       8'h1C
`define CTRL_ENABLE    0
`define CTRL_TRIGGERED 1
`define CTRL_LEVEL     2
`define CTRL_LVL_EXPO  3
`define CTRL_SW_LEVEL  4
`define FMT_LSB        0
`define DEPTH_LSB      4
`define FMT_SHIFT      6
`define FMT_PACK       7
`define FMT_RAW_BYTE_FORMAT       3'h0
`define FMT_RAW_WORD_FORMAT      3'h1
`define FMT_INT8       3'h2
`define FMT_INT16      3'h3
`define FMT_COL3       3'h4
`define FMT_COL4       3'h5
`define FMT_PLANAR     3'h6
`define FMT_PASS       3'h7
`define DEPTH_8        2'h0
`define DEPTH_10       2'h1
`define DEPTH_12       2'h2
`define EDGE_CROP      16'h0004
`define LAST_PLANE     2'h2
`define EXPOSURE_RST   32'h0000_0100
`define GEOMETRY_RST   32'h0010_0010
`define ZERO32         32'h0000_0000
`endif

//--- inc/cam_acq_pkg.sv
// Types shared by the acquisition sequencer and pixel formatter
package cam_acq_pkg;
	typedef enum logic [1:0] {
		S_IDLE,
		S_EXPOSE,
		S_HOLD
	} acq_state_type;
endpackage

//--- verilog/cam_acq.sv
// Acquisition sequencer and output pixel formatter of the camera
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "cam_acq_consts.svh"

// How it works
// - Continuous mode starts each exposure by itself as soon as allowed.
// - Pixels stream out every cycle the sensor supplies them, except cropped colour edges and the first pixel of each packed pair.
// - Next exposure may start while the previous readout is still running.
// - Frame starts wait until the minimum frame period has elapsed, any mode.
// - Triggered mode idles until a trigger, then exposes, then reads out.
// - Trigger sensitivity is selectable: rising edge or active level.
// - Level trigger governs either exposure length or the acquisition span.
// - A software trigger written over the register port is accepted.
// - The hardware trigger input pin is accepted as a frame request.
// - Raw formats give one unprocessed sample, 8 or 16 bits.
// - Raw 16-bit keeps 10/12-bit samples low, optionally shifted to the top.
// - Intensity formats give one channel per pixel, 8 or 16 bits.
// - Three-byte colour emits blue, green, red.
// - Four-byte colour emits blue, green, red, then a zero alpha byte.
// - Planar colour sends all red, then all green, then all blue.
// - Colour output drops four edge pixels on every side.
// - Choosing an interleaved colour format resets the region of interest.
// - Packed transport puts 12-bit pixels in 12 bits on the link.
// - Passthrough sends link data unchanged, layout set by its own setting.
// - Programmed exposure value sets the integration length.
module cam_acq
	import cam_acq_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_nrst,
	// Register port
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [31:0] i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [31:0] o_reg_rdata,
	// Trigger pin
	input  wire logic        i_trigger_pin,
	// Sensor side
	output logic             o_expose,
	output logic             o_readout_req,
	input  wire logic        i_pix_valid,
	input  wire logic [15:0] i_pix_data,
	input  wire logic [7:0]  i_pix_red,
	input  wire logic [7:0]  i_pix_green,
	input  wire logic [7:0]  i_pix_blue,
	input  wire logic        i_pix_eol,
	input  wire logic        i_pix_eof,
	// Link side
	output logic             o_link_valid,
	output logic      [31:0] o_link_data,
	output logic      [2:0]  o_link_bytes,
	output logic             o_link_sof,
	output logic             o_link_eof
);

	//----------------------------------------
	// Registers
	//----------------------------------------
	logic [31:0]   ctrl_q;
	logic [31:0]   exp_len_q;
	logic [31:0]   min_per_q;
	logic [31:0]   format_q;
	logic [31:0]   geom_q;
	logic [31:0]   roi_q;
	logic          soft_pulse_q;
	logic [15:0]   frames_q;
	acq_state_type st_q;
	logic [31:0]   exp_cnt_q;
	logic [31:0]   per_cnt_q;
	logic          pend_q;
	logic          rd_busy_q;
	logic [1:0]    plane_q;
	logic          trig_meta_q;
	logic          trig_sync_q;
	logic          trig_prev_q;
	logic [15:0]   col_q;
	logic [15:0]   row_q;
	logic          half_q;
	logic [11:0]   hold_q;
	logic          first_q;

	logic [2:0]  fmt;
	logic [1:0]  depth;
	logic        colour;
	logic        trig_lvl;
	logic        trig_edge;
	logic        rate_ok;
	logic        go;
	logic        exp_done;
	logic        wr_ctrl;
	logic        last_plane;

	assign fmt        = format_q[`FMT_LSB +: 3];
	assign depth      = format_q[`DEPTH_LSB +: 2];
	assign colour     = (fmt == `FMT_COL3) || (fmt == `FMT_COL4) || (fmt == `FMT_PLANAR);
	assign wr_ctrl    = i_reg_wr && (i_reg_addr == `ADDR_FORMAT);
	assign last_plane = (fmt != `FMT_PLANAR) || (plane_q == `LAST_PLANE);

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_q    <= `ZERO32;
			exp_len_q <= `EXPOSURE_RST;
			min_per_q <= `ZERO32;
			format_q  <= `ZERO32;
			geom_q    <= `GEOMETRY_RST;
		end else if (i_reg_wr) begin
			unique case (i_reg_addr)
				`ADDR_CTRL:     ctrl_q    <= i_reg_wdata;
				`ADDR_EXPOSURE: exp_len_q <= i_reg_wdata;
				`ADDR_MIN_PER:  min_per_q <= i_reg_wdata;
				`ADDR_FORMAT:   format_q  <= i_reg_wdata;
				`ADDR_GEOMETRY: geom_q    <= i_reg_wdata;
				default: ;
			endcase
		end
	end

	// Interleaved colour needs the full frame, so the window falls back to it
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			roi_q <= `ZERO32;
		end else if (wr_ctrl && ((i_reg_wdata[`FMT_LSB +: 3] == `FMT_COL3) ||
				(i_reg_wdata[`FMT_LSB +: 3] == `FMT_COL4))) begin
			roi_q <= `ZERO32;
		end else if (i_reg_wr && (i_reg_addr == `ADDR_ROI)) begin
			roi_q <= i_reg_wdata;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			soft_pulse_q <= 1'b0;
		end else begin
			soft_pulse_q <= i_reg_wr && (i_reg_addr == `ADDR_SOFT_TRIG);
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_reg_rdata <= `ZERO32;
		end else if (i_reg_rd) begin
			unique case (i_reg_addr)
				`ADDR_CTRL:     o_reg_rdata <= ctrl_q;
				`ADDR_EXPOSURE: o_reg_rdata <= exp_len_q;
				`ADDR_MIN_PER:  o_reg_rdata <= min_per_q;
				`ADDR_FORMAT:   o_reg_rdata <= format_q;
				`ADDR_GEOMETRY: o_reg_rdata <= geom_q;
				`ADDR_ROI:      o_reg_rdata <= roi_q;
				`ADDR_STATUS:   o_reg_rdata <= {frames_q, 10'h000, plane_q,
						(st_q == S_HOLD), pend_q, rd_busy_q, o_expose};
				default:        o_reg_rdata <= `ZERO32;
			endcase
		end else begin
			o_reg_rdata <= `ZERO32;
		end
	end

	//----------------------------------------
	// Trigger
	//----------------------------------------
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			trig_meta_q <= 1'b0;
			trig_sync_q <= 1'b0;
			trig_prev_q <= 1'b0;
		end else begin
			trig_meta_q <= i_trigger_pin;
			trig_sync_q <= trig_meta_q;
			trig_prev_q <= trig_sync_q;
		end
	end

	// Rising edge only; a falling-edge source must be inverted upstream
	assign trig_edge = (trig_sync_q && !trig_prev_q) || soft_pulse_q;
	assign trig_lvl  = trig_sync_q || ctrl_q[`CTRL_SW_LEVEL];

	// Set wins over the clear taken at frame start
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			pend_q <= 1'b0;
		end else if (trig_edge) begin
			pend_q <= 1'b1;
		end else if (go || !ctrl_q[`CTRL_TRIGGERED]) begin
			pend_q <= 1'b0;
		end
	end

	//----------------------------------------
	// Acquisition sequencer
	//----------------------------------------
	assign rate_ok = (min_per_q == `ZERO32) || (per_cnt_q >= min_per_q);

	always_comb begin
		go = 1'b0;
		if (ctrl_q[`CTRL_ENABLE] && (st_q == S_IDLE) && rate_ok) begin
			if (!ctrl_q[`CTRL_TRIGGERED]) begin
				go = 1'b1;
			end else if (ctrl_q[`CTRL_LEVEL]) begin
				go = trig_lvl;
			end else begin
				go = pend_q;
			end
		end
	end

	always_comb begin
		if (ctrl_q[`CTRL_TRIGGERED] && ctrl_q[`CTRL_LEVEL] && ctrl_q[`CTRL_LVL_EXPO]) begin
			exp_done = !trig_lvl;
		end else begin
			exp_done = (exp_cnt_q + 32'h1) >= exp_len_q;
		end
	end

	// An exposure may start during a readout; one ending while it is busy holds in S_HOLD, blocking the next start and its readout request
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			st_q <= S_IDLE;
		end else begin
			unique case (st_q)
				S_IDLE: begin
					if (go) begin
						st_q <= S_EXPOSE;
					end
				end
				S_EXPOSE: begin
					if (exp_done) begin
						st_q <= rd_busy_q ? S_HOLD : S_IDLE;
					end
				end
				S_HOLD: begin
					if (!rd_busy_q) begin
						st_q <= S_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_expose <= 1'b0;
		end else begin
			o_expose <= go || ((st_q == S_EXPOSE) && !exp_done);
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			exp_cnt_q <= `ZERO32;
		end else if (st_q == S_EXPOSE) begin
			exp_cnt_q <= exp_cnt_q + 32'h1;
		end else begin
			exp_cnt_q <= `ZERO32;
		end
	end

	// Saturates so a long pause never wraps into a false too-early verdict
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			per_cnt_q <= `ZERO32;
		end else if (go) begin
			per_cnt_q <= 32'h1;
		end else if (per_cnt_q != 32'hFFFF_FFFF) begin
			per_cnt_q <= per_cnt_q + 32'h1;
		end
	end

	//----------------------------------------
	// Readout control
	//----------------------------------------
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_readout_req <= 1'b0;
			rd_busy_q     <= 1'b0;
			plane_q       <= 2'h0;
			frames_q      <= 16'h0000;
		end else begin
			o_readout_req <= 1'b0;
			if (!rd_busy_q && (((st_q == S_EXPOSE) && exp_done) || (st_q == S_HOLD))) begin
				o_readout_req <= 1'b1;
				rd_busy_q     <= 1'b1;
				plane_q       <= 2'h0;
			end else if (rd_busy_q && i_pix_valid && i_pix_eof) begin
				if (last_plane) begin
					rd_busy_q <= 1'b0;
					frames_q  <= frames_q + 16'h1;
				end else begin
					o_readout_req <= 1'b1;
					plane_q       <= plane_q + 2'h1;
				end
			end
		end
	end

	//----------------------------------------
	// Pixel formatter
	//----------------------------------------
	logic        keep;
	logic [7:0]  chan;
	logic [9:0]  luma;
	logic [15:0] raw_word_format;
	logic [7:0]  raw_byte_format;
	logic [31:0] col4;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			col_q <= 16'h0000;
			row_q <= 16'h0000;
		end else if (i_pix_valid) begin
			col_q <= i_pix_eol ? 16'h0000 : col_q + 16'h1;
			if (i_pix_eof) begin
				row_q <= 16'h0000;
			end else if (i_pix_eol) begin
				row_q <= row_q + 16'h1;
			end
		end
	end

	assign keep = !colour || ((col_q >= `EDGE_CROP) && (row_q >= `EDGE_CROP) &&
			(col_q < geom_q[15:0] - `EDGE_CROP) &&
			(row_q < geom_q[31:16] - `EDGE_CROP));

	assign luma = {2'h0, i_pix_red} + {1'h0, i_pix_green, 1'h0} + {2'h0, i_pix_blue};
	assign col4 = {8'h00, i_pix_red, i_pix_green, i_pix_blue};

	always_comb begin
		unique case (plane_q)
			2'h0:    chan = i_pix_red;
			2'h1:    chan = i_pix_green;
			default: chan = i_pix_blue;
		endcase
	end

	always_comb begin
		unique case (depth)
			`DEPTH_10: begin
				raw_byte_format  = i_pix_data[9:2];
				raw_word_format = format_q[`FMT_SHIFT] ? {i_pix_data[9:0], 6'h00} : i_pix_data;
			end
			`DEPTH_12: begin
				raw_byte_format  = i_pix_data[11:4];
				raw_word_format = format_q[`FMT_SHIFT] ? {i_pix_data[11:0], 4'h0} : i_pix_data;
			end
			default: begin
				raw_byte_format  = i_pix_data[7:0];
				raw_word_format = format_q[`FMT_SHIFT] ? {i_pix_data[7:0], 8'h00} : i_pix_data;
			end
		endcase
	end

	// Packer pair state; a frame's odd last pixel leaves as two bytes
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			half_q <= 1'b0;
			hold_q <= 12'h000;
		end else if (o_readout_req) begin
			half_q <= 1'b0;
		end else if (i_pix_valid && (fmt == `FMT_PASS) && format_q[`FMT_PACK]) begin
			half_q <= !half_q && !i_pix_eof;
			hold_q <= i_pix_data[11:0];
		end
	end

	// One register stage, no stall: the link must take every beat
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_link_valid <= 1'b0;
			o_link_data  <= `ZERO32;
			o_link_bytes <= 3'h0;
			o_link_sof   <= 1'b0;
			o_link_eof   <= 1'b0;
			first_q      <= 1'b0;
		end else begin
			o_link_valid <= 1'b0;
			o_link_data  <= `ZERO32;
			o_link_bytes <= 3'h0;
			o_link_sof   <= 1'b0;
			o_link_eof   <= rd_busy_q && i_pix_valid && i_pix_eof;
			if (o_readout_req) begin
				first_q <= 1'b1;
			end
			if (rd_busy_q && i_pix_valid && keep) begin
				o_link_valid <= 1'b1;
				o_link_sof   <= first_q;
				first_q      <= 1'b0;
				unique case (fmt)
					`FMT_RAW_BYTE_FORMAT: begin
						o_link_data  <= {24'h000000, raw_byte_format};
						o_link_bytes <= 3'h1;
					end
					`FMT_RAW_WORD_FORMAT: begin
						o_link_data  <= {16'h0000, raw_word_format};
						o_link_bytes <= 3'h2;
					end
					`FMT_INT8: begin
						o_link_data  <= {24'h000000, luma[9:2]};
						o_link_bytes <= 3'h1;
					end
					`FMT_INT16: begin
						o_link_data  <= {16'h0000, luma, 6'h00};
						o_link_bytes <= 3'h2;
					end
					`FMT_COL3: begin
						o_link_data  <= {8'h00, col4[23:0]};
						o_link_bytes <= 3'h3;
					end
					`FMT_COL4: begin
						o_link_data  <= col4;
						o_link_bytes <= 3'h4;
					end
					`FMT_PLANAR: begin
						o_link_data  <= {24'h000000, chan};
						o_link_bytes <= 3'h1;
					end
					default: begin
						if (!format_q[`FMT_PACK]) begin
							o_link_data  <= {16'h0000, i_pix_data};
							o_link_bytes <= 3'h2;
						end else if (half_q) begin
							o_link_data  <= {8'h00, i_pix_data[11:0], hold_q};
							o_link_bytes <= 3'h3;
						end else if (i_pix_eof) begin
							o_link_data  <= {20'h00000, i_pix_data[11:0]};
							o_link_bytes <= 3'h2;
						end else begin
							o_link_valid <= 1'b0;
							o_link_sof   <= 1'b0;
							first_q      <= first_q;
						end
					end
				endcase
			end
		end
	end

	//----------------------------------------
	// Assertions
	//----------------------------------------
	a_edge_start: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(go && ctrl_q[`CTRL_TRIGGERED] && !ctrl_q[`CTRL_LEVEL]) |-> pend_q)
		else $error("triggered start without pending trigger");
	a_rate_cap: assert property (@(posedge i_clock) disable iff (!i_nrst)
		($rose(o_expose) && (min_per_q != `ZERO32)) |-> ($past(per_cnt_q) >= min_per_q))
		else $error("frame started before minimum period");
	a_free_overlap: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(ctrl_q[`CTRL_ENABLE] && !ctrl_q[`CTRL_TRIGGERED] && (st_q == S_IDLE) && rate_ok)
		|=> o_expose)
		else $error("free run did not start exposure");
	a_expo_length: assert property (@(posedge i_clock) disable iff (!i_nrst)
		($fell(o_expose) && !ctrl_q[`CTRL_LEVEL] && $stable(exp_len_q))
		|-> ($past(exp_cnt_q) + 32'h1 == exp_len_q) || (exp_len_q <= 32'h1))
		else $error("exposure length differs from setting");
	a_req_free: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(o_readout_req && ($past(plane_q) == plane_q)) |-> !$past(rd_busy_q))
		else $error("readout requested while busy");
	a_alpha_zero: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(o_link_valid && (fmt == `FMT_COL4) && $stable(format_q))
		|-> (o_link_bytes == 3'h4) && (o_link_data[31:24] == 8'h00)
		&& (o_link_data[7:0] == $past(i_pix_blue)))
		else $error("four byte colour malformed");
	a_three_byte: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(o_link_valid && (fmt == `FMT_COL3) && $stable(format_q))
		|-> (o_link_bytes == 3'h3) && (o_link_data[23:16] == $past(i_pix_red)))
		else $error("three byte colour malformed");
	a_edge_crop: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(i_pix_valid && colour && (col_q < `EDGE_CROP)) |=> !o_link_valid)
		else $error("edge pixel not discarded");
	a_packed: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(o_link_valid && (fmt == `FMT_PASS) && format_q[`FMT_PACK] && $stable(format_q))
		|-> (o_link_bytes == 3'h3) || ((o_link_bytes == 3'h2) && o_link_eof))
		else $error("packed pixel width wrong");
	a_roi_reset: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(wr_ctrl && (i_reg_wdata[`FMT_LSB +: 3] == `FMT_COL4)) |=> (roi_q == `ZERO32))
		else $error("colour format did not reset window");

endmodule
`default_nettype wire

//--- tb/sensor_model.sv
// Behavioural image sensor streaming one frame per readout request
`timescale 1ns/10ps
`default_nettype none
module sensor_model (
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_nrst,
	// Control
	input  wire logic        i_readout_req,
	input  wire logic        i_slow,
	input  wire logic [7:0]  i_width,
	input  wire logic [7:0]  i_height,
	// Pixel stream
	output logic             o_pix_valid,
	output logic      [15:0] o_pix_data,
	output logic      [7:0]  o_pix_red,
	output logic      [7:0]  o_pix_green,
	output logic      [7:0]  o_pix_blue,
	output logic             o_pix_eol,
	output logic             o_pix_eof,
	output logic             o_streaming
);
	int         pend;
	int         delay;
	logic       act;
	logic       stall;
	logic       last_col;
	logic [7:0] row;
	logic [7:0] col;

	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			pend = 0;
			act = 1'b0;
			stall = 1'b0;
			o_pix_valid <= 1'b0;
			o_pix_data <= 16'h0000;
			o_pix_red <= 8'h00;
			o_pix_green <= 8'h00;
			o_pix_blue <= 8'h00;
			o_pix_eol <= 1'b0;
			o_pix_eof <= 1'b0;
			o_streaming <= 1'b0;
		end else begin
			pend = pend + int'(i_readout_req);
			stall = ~stall;
			last_col = (col == i_width - 8'h01);
			if (!act && pend > 0) begin
				pend = pend - 1;
				act = 1'b1;
				row = 8'h00;
				col = 8'h00;
				// Slow mode: long latency and a stall every other cycle
				delay = i_slow ? 20 : 2;
			end else if (act && delay > 0) begin
				delay = delay - 1;
			end
			if (act && delay == 0 && !(i_slow && stall)) begin
				o_pix_valid <= 1'b1;
				o_pix_data <= {8'h0A, row[3:0], col[3:0]};
				o_pix_red <= {4'h4, col[3:0]};
				o_pix_green <= {4'h2, row[3:0]};
				o_pix_blue <= {4'hC, col[3:0]};
				o_pix_eol <= last_col;
				o_pix_eof <= last_col && (row == i_height - 8'h01);
				if (last_col && row == i_height - 8'h01) begin
					act = 1'b0;
				end
				row = last_col ? row + 8'h01 : row;
				col = last_col ? 8'h00 : col + 8'h01;
			end else begin
				// Idle lines toggle so a stale sample never looks valid
				o_pix_valid <= 1'b0;
				o_pix_eol <= 1'b0;
				o_pix_eof <= 1'b0;
				o_pix_data <= ~o_pix_data;
				o_pix_red <= ~o_pix_red;
				o_pix_green <= ~o_pix_green;
				o_pix_blue <= ~o_pix_blue;
			end
			o_streaming <= act;
		end
	end
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench of the acquisition sequencer and pixel formatter
`timescale 1ns/10ps
`default_nettype none
`include "cam_acq_consts.svh"
module tb;
	typedef struct {
		logic [7:0]  fmt;
		logic [31:0] first;
		logic [2:0]  bytes;
		int          beats;
		logic [31:0] last;
		int          planes;
	} row_type;
	logic i_clock = 1'b0, i_nrst, i_reg_wr, i_reg_rd, i_trigger_pin, slow;
	logic [7:0]  i_reg_addr;
	logic [31:0] i_reg_wdata, o_reg_rdata, o_link_data, first_data, last_data, mask;
	logic o_expose, o_readout_req, o_link_valid, o_link_sof, o_link_eof, streaming;
	logic pv, eol, eof, first_sof, exp_prev, overlap;
	logic [15:0] pd;
	logic [7:0]  pr, pg, pb;
	logic [2:0]  o_link_bytes, first_bytes;
	int cyc, beats, eofs, rises, hi_cnt, last_len, t_rise, min_gap, t_first, t_last;
	int mismatches, total_checks;
	row_type rows [11];

	always #2.5 i_clock = ~i_clock;

	cam_acq u_cam_acq (.i_clock(i_clock), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.o_reg_rdata(o_reg_rdata), .i_trigger_pin(i_trigger_pin), .o_expose(o_expose),
		.o_readout_req(o_readout_req), .i_pix_valid(pv), .i_pix_data(pd), .i_pix_red(pr),
		.i_pix_green(pg), .i_pix_blue(pb), .i_pix_eol(eol), .i_pix_eof(eof),
		.o_link_valid(o_link_valid), .o_link_data(o_link_data), .o_link_bytes(o_link_bytes),
		.o_link_sof(o_link_sof), .o_link_eof(o_link_eof));
	sensor_model u_sensor_model (.i_clock(i_clock), .i_nrst(i_nrst),
		.i_readout_req(o_readout_req), .i_slow(slow), .i_width(8'h0A), .i_height(8'h0A),
		.o_pix_valid(pv), .o_pix_data(pd), .o_pix_red(pr), .o_pix_green(pg),
		.o_pix_blue(pb), .o_pix_eol(eol), .o_pix_eof(eof), .o_streaming(streaming));

	// ----------------------------------------
	// Monitor and timeout
	// ----------------------------------------
	always @(posedge i_clock) begin
		cyc = cyc + 1;
		if (o_link_valid === 1'b1) begin
			if (beats == 0) begin
				first_data = o_link_data;
				first_bytes = o_link_bytes;
				first_sof = o_link_sof;
				t_first = cyc;
			end
			last_data = o_link_data;
			t_last = cyc;
			beats++;
		end
		eofs = eofs + int'(o_link_eof === 1'b1);
		if (o_expose === 1'b1) begin
			hi_cnt++;
		end else if (hi_cnt != 0) begin
			last_len = hi_cnt;
			hi_cnt = 0;
		end
		if (o_expose === 1'b1 && exp_prev !== 1'b1) begin
			if (rises > 0 && cyc - t_rise < min_gap) min_gap = cyc - t_rise;
			rises++;
			t_rise = cyc;
			if (streaming) overlap = 1'b1;
		end
		exp_prev = o_expose;
		if (cyc == 30000) begin
			mismatches++;
			stop_test();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wcyc(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clock);
		i_reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_clock);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_clock);
		i_reg_rd <= 1'b0;
		#1;
		check(what, o_reg_rdata, exp);
	endtask
	task automatic pin(input logic v);
		@(posedge i_clock);
		i_trigger_pin <= v;
		#1;
	endtask
	task automatic clr();
		beats = 0;
		eofs = 0;
		rises = 0;
		overlap = 1'b0;
		min_gap = 99999;
		last_len = 0;
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		// Mostly depth 12; sample = {A,row,col}, red 4col, green 2row, blue Ccol, 10x10 frame
		// Intensity 16 is the full ten-bit sum r+2g+b placed at the top of the word
		rows = '{'{8'h20, 32'hA0, 3'h1, 100, 32'hA9, 1}, '{8'h21, 32'hA00, 3'h2, 100, 32'hA99, 1},
			'{8'h61, 32'hA000, 3'h2, 100, 32'hA990, 1}, '{8'h22, 32'h50, 3'h1, 100, 32'h59, 1},
			'{8'h23, 32'h5000, 3'h2, 100, 32'h5900, 1}, '{8'h00, 32'h00, 3'h1, 100, 32'h99, 1},
			'{8'h51, 32'h8000, 3'h2, 100, 32'hA640, 1},
			'{8'h24, 32'h4424C4, 3'h3, 4, 32'h4525C5, 1},
			'{8'h25, 32'h4424C4, 3'h4, 4, 32'h4525C5, 1}, '{8'h26, 32'h44, 3'h1, 12, 32'hC5, 3},
			'{8'hA7, 32'hA01A00, 3'h3, 50, 32'hA99A98, 1}};
		{i_nrst, i_reg_wr, i_reg_rd, i_trigger_pin, slow} = 5'h00;
		i_reg_addr = 8'h00;
		i_reg_wdata = 32'h0000_0000;
		repeat (3) @(posedge i_clock);
		i_nrst <= 1'b1;
		#1;
		check("expose rst", o_expose, 1'b0);
		check("link rst", o_link_valid, 1'b0);
		rdc("exposure rst", `ADDR_EXPOSURE, `EXPOSURE_RST);
		rdc("geometry rst", `ADDR_GEOMETRY, `GEOMETRY_RST);
		wr(8'h40, 32'hFFFF_FFFF);
		rdc("unmapped", 8'h40, `ZERO32);
		wr(`ADDR_GEOMETRY, 32'h000A_000A);
		wr(`ADDR_EXPOSURE, 32'h0000_0003);
		wr(`ADDR_CTRL, 32'h0000_0003);
		clr();
		wcyc(100);
		check("idle rises", rises, 0);
		$display("test reset and idle done");
		for (int i = 0; i < 11; i++) begin
			wr(`ADDR_FORMAT, {24'h0, rows[i].fmt});
			clr();
			wr(`ADDR_SOFT_TRIG, 32'h0000_0001);
			for (int n = 0; n < 3000 && eofs < rows[i].planes; n++) wcyc(1);
			wcyc(20);
			mask = (rows[i].bytes == 3'h4) ? 32'hFFFF_FFFF : (32'h1 << (8 * rows[i].bytes)) - 32'h1;
			check("first data", first_data & mask, rows[i].first);
			check("last data", last_data & mask, rows[i].last);
			check("bytes", first_bytes, rows[i].bytes);
			check("beats", beats, rows[i].beats);
			check("eofs", eofs, rows[i].planes);
			check("sof", first_sof, 1'b1);
			check("soft trig", rises, 1);
			check("expose len", last_len, 3);
			if (rows[i].fmt[2:0] < 3'h4) check("gapless", t_last - t_first + 1, beats);
			$display("test format %h done", rows[i].fmt);
		end
		for (int j = 4; j < 6; j++) begin
			wr(`ADDR_FORMAT, 32'h0000_0020);
			wr(`ADDR_ROI, 32'h0000_0055);
			rdc("roi kept", `ADDR_ROI, 32'h0000_0055);
			wr(`ADDR_FORMAT, 32'h0000_0020 | j);
			rdc("roi cleared", `ADDR_ROI, `ZERO32);
		end
		$display("test roi done");
		wr(`ADDR_CTRL, 32'h0000_0003);
		clr();
		pin(1'b1);
		wcyc(60);
		pin(1'b0);
		wcyc(300);
		check("edge pin", rises, 1);
		wr(`ADDR_CTRL, 32'h0000_0007);
		clr();
		pin(1'b1);
		wcyc(400);
		pin(1'b0);
		wcyc(300);
		check("level span", rises > 1, 1'b1);
		clr();
		wcyc(200);
		check("level low", rises, 0);
		wr(`ADDR_CTRL, 32'h0000_000F);
		clr();
		pin(1'b1);
		wcyc(40);
		pin(1'b0);
		wcyc(300);
		check("level expose", last_len >= 38 && last_len <= 42, 1'b1);
		wr(`ADDR_CTRL, 32'h0000_0017);
		clr();
		wcyc(400);
		wr(`ADDR_CTRL, 32'h0000_0000);
		wcyc(300);
		check("soft level", rises > 1, 1'b1);
		$display("test triggers done");
		slow <= 1'b1;
		wr(`ADDR_CTRL, 32'h0000_0001);
		clr();
		wcyc(1500);
		wr(`ADDR_CTRL, 32'h0000_0000);
		check("free run", rises > 2, 1'b1);
		check("overlap", overlap, 1'b1);
		check("free len", last_len, 3);
		wcyc(600);
		wr(`ADDR_MIN_PER, 32'h0000_0190);
		wr(`ADDR_CTRL, 32'h0000_0001);
		clr();
		wcyc(2000);
		check("period gap", min_gap >= 400 && rises > 2, 1'b1);
		$display("test free run done");
		@(posedge i_clock);
		i_nrst <= 1'b0;
		wcyc(3);
		check("mid reset", {o_expose, o_readout_req, o_link_valid}, 3'h0);
		@(posedge i_clock);
		i_nrst <= 1'b1;
		rdc("exposure rst2", `ADDR_EXPOSURE, `EXPOSURE_RST);
		rdc("status rst2", `ADDR_STATUS, `ZERO32);
		$display("test second reset done");
		stop_test();
	end
endmodule
`default_nettype wire
